// ### common/test_if_map.vh
/*
 * Register offsets, field positions, reset values, tap codes and timing
 * counts of the test interface front end. Assumes a byte-wide register
 * port with 4-bit addresses and a 200 MHz block clock.
 */
// Behaviour
// - mode pins 00 enable srom, terminal, tap
// - other mode patterns select factory test, ports idle
// - shared receive pin takes srom or terminal data
// - shared clock pin clocks srom or transmits; enable
// - status pin shows written value and timeout pulse
// - tap controls boundary register and chip tristate
// - scan active only with mode 00, power good
// - no retire for billion cycles: 256-cycle pulse
// - reset forces status pin low until written
// - instruction capture loads 00001
`ifndef TEST_IF_MAP_VH
`define TEST_IF_MAP_VH

// register offsets
`define TIM_REG_CTRL      4'h0
`define TIM_REG_STATE     4'h1
`define TIM_REG_RXDATA    4'h2
`define TIM_REG_IRQ_STAT  4'h3
`define TIM_REG_IRQ_MASK  4'h4
`define TIM_REG_IR        4'h5

// control fields
`define TIM_CTRL_STATUS   0
`define TIM_CTRL_SROM_RUN 1
`define TIM_CTRL_TERM     2
`define TIM_CTRL_TX       3
`define TIM_CTRL_RESET    4'h0

// state fields
`define TIM_ST_MODE_OK    0
`define TIM_ST_SCAN_EN    1
`define TIM_ST_FITTED     2
`define TIM_ST_RX         3
`define TIM_ST_PULSE      4

// event bits, shared by status and mask
`define TIM_EV_TIMEOUT    0
`define TIM_EV_RX_BYTE    1
`define TIM_EV_MODE_BAD   2
`define TIM_EV_SCAN_CHG   3

// instruction codes
`define TIM_IR_EXTEST     5'h00
`define TIM_IR_SAMPLE     5'h01
`define TIM_IR_CLAMP      5'h04
`define TIM_IR_HIGHZ      5'h05
`define TIM_IR_BYPASS     5'h1f
`define TIM_IR_CAPTURE    5'h01

// timing counts in block clock cycles
`define TIM_TIMEOUT_CYCLES 32'h3b9aca00
`define TIM_PULSE_CYCLES   9'h100
`define TIM_SROM_HALF      4'h8

`endif

// ### logic/tap_core.v
/*
 * Boundary-scan access port controller: sixteen-state machine, 5-bit
 * instruction register and bypass bit. Assumes tck edges, tms, tdi and
 * trst_n arrive already synchronised to the block clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "test_if_map.vh"
module tap_core (
    // clock and reset
    input  wire       clock,
    input  wire       rst,
    // gating and pins
    input  wire       enable,
    input  wire       tck_rise,
    input  wire       tck_fall,
    input  wire       tms,
    input  wire       tdi,
    input  wire       trst_n,
    input  wire       bsr_tdo,
    // results
    output reg        tdo_ff,
    output reg        tdo_oe_ff,
    output reg        highz_ff,
    output reg        extest_ff,
    output reg        bsr_capture_ff,
    output reg        bsr_shift_ff,
    output reg        bsr_update_ff,
    output wire [4:0] ir_out
);
    localparam [3:0] S_TLR = 4'h0, S_RTI = 4'h1, S_SDR = 4'h2;
    localparam [3:0] S_CDR = 4'h3, S_SHD = 4'h4, S_E1D = 4'h5;
    localparam [3:0] S_PD  = 4'h6, S_E2D = 4'h7, S_UDR = 4'h8;
    localparam [3:0] S_SIR = 4'h9, S_CIR = 4'ha, S_SHI = 4'hb;
    localparam [3:0] S_E1I = 4'hc, S_PI  = 4'hd, S_E2I = 4'he;
    localparam [3:0] S_UIR = 4'hf;

    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg [4:0] ir_ff;
    reg [4:0] ir_sh_ff;
    reg       bypass_ff;
    wire      bsr_sel = (ir_ff[4:2] == 3'h0);
    wire      step = tck_rise;

    assign ir_out = ir_ff;

    always @* begin
        case (state_ff)
            S_TLR: nxt_state = tms ? S_TLR : S_RTI;
            S_RTI: nxt_state = tms ? S_SDR : S_RTI;
            S_SDR: nxt_state = tms ? S_SIR : S_CDR;
            S_CDR: nxt_state = tms ? S_E1D : S_SHD;
            S_SHD: nxt_state = tms ? S_E1D : S_SHD;
            S_E1D: nxt_state = tms ? S_UDR : S_PD;
            S_PD:  nxt_state = tms ? S_E2D : S_PD;
            S_E2D: nxt_state = tms ? S_UDR : S_SHD;
            S_UDR: nxt_state = tms ? S_SDR : S_RTI;
            S_SIR: nxt_state = tms ? S_TLR : S_CIR;
            S_CIR: nxt_state = tms ? S_E1I : S_SHI;
            S_SHI: nxt_state = tms ? S_E1I : S_SHI;
            S_E1I: nxt_state = tms ? S_UIR : S_PI;
            S_PI:  nxt_state = tms ? S_E2I : S_PI;
            S_E2I: nxt_state = tms ? S_UIR : S_SHI;
            S_UIR: nxt_state = tms ? S_SDR : S_RTI;
            default: nxt_state = S_TLR;
        endcase
    end

    always @(posedge clock) begin
        if (rst || !enable || !trst_n) begin
            // held in reset while the enable pattern is missing
            state_ff       <= S_TLR;
            ir_ff          <= `TIM_IR_BYPASS;
            ir_sh_ff       <= `TIM_IR_CAPTURE;
            bypass_ff      <= 1'b0;
            tdo_ff         <= 1'b0;
            tdo_oe_ff      <= 1'b0;
            highz_ff       <= 1'b0;
            extest_ff      <= 1'b0;
            bsr_capture_ff <= 1'b0;
            bsr_shift_ff   <= 1'b0;
            bsr_update_ff  <= 1'b0;
        end else begin
            bsr_capture_ff <= step && bsr_sel && state_ff == S_CDR;
            bsr_shift_ff   <= step && bsr_sel && state_ff == S_SHD;
            bsr_update_ff  <= step && bsr_sel && state_ff == S_UDR;
            highz_ff       <= (ir_ff == `TIM_IR_HIGHZ);
            extest_ff      <= (ir_ff == `TIM_IR_EXTEST) ||
                              (ir_ff == `TIM_IR_CLAMP);
            if (step) begin
                state_ff <= nxt_state;
                case (state_ff)
                    S_TLR: ir_ff <= `TIM_IR_BYPASS;
                    S_CIR: ir_sh_ff <= `TIM_IR_CAPTURE;
                    S_SHI: ir_sh_ff <= {tdi, ir_sh_ff[4:1]};
                    S_UIR: ir_ff <= ir_sh_ff;
                    S_CDR: bypass_ff <= 1'b0;
                    S_SHD: bypass_ff <= tdi;
                    default: bypass_ff <= bypass_ff;
                endcase
            end
            if (tck_fall) begin
                tdo_oe_ff <= (state_ff == S_SHI) || (state_ff == S_SHD);
                if (state_ff == S_SHI)
                    tdo_ff <= ir_sh_ff[0];
                else if (bsr_sel)
                    tdo_ff <= bsr_tdo;
                else
                    tdo_ff <= bypass_ff;
            end
        end
    end
endmodule // tap_core
`default_nettype wire

// ### logic/test_interface_mode_select.v
/*
 * Test interface front end: mode pin decode, serial rom / diagnostic
 * terminal port, boundary-scan port gating, status pin and interrupt
 * registers. Assumes all pins are asynchronous to clock and that the
 * core supplies retire and system clock tick pulses on clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "test_if_map.vh"
module test_interface_mode_select #(
    parameter [31:0] TIMEOUT_CYCLES = `TIM_TIMEOUT_CYCLES
) (
    // clock and reset
    input  wire       clock,
    input  wire       rst,
    // register port
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata_ff,
    // mode and power pins
    input  wire [1:0] port_mode_in,
    input  wire       power_good_in,
    input  wire       srom_fitted_n_in,
    // serial rom / terminal pins
    input  wire       serial_rx_in,
    output reg        serial_clk_tx_ff,
    output reg        srom_enable_n_ff,
    // scan access pins
    input  wire       tck_in,
    input  wire       tms_in,
    input  wire       tdi_in,
    input  wire       trst_n_in,
    output wire       tdo_out,
    output wire       tdo_oe,
    // boundary register and chip control
    input  wire       bsr_tdo_in,
    output wire       bsr_capture,
    output wire       bsr_shift,
    output wire       bsr_update,
    output wire       bsr_drive_pins,
    output wire       chip_tristate,
    // core events
    input  wire       retire,
    input  wire       sys_tick,
    // status and interrupt
    output reg        test_status_ff,
    output reg        irq_ff
);
    localparam NSYNC = 9;
    localparam SI_TCK = 0, SI_TMS = 1, SI_TDI = 2, SI_TRST = 3;
    localparam SI_MODE0 = 4, SI_MODE1 = 5, SI_PGOOD = 6;
    localparam SI_FIT = 7, SI_RX = 8;

    wire [NSYNC-1:0] pins_raw = {serial_rx_in, srom_fitted_n_in,
                                 power_good_in, port_mode_in,
                                 trst_n_in, tdi_in, tms_in, tck_in};
    reg  [NSYNC-1:0] meta_ff;
    reg  [NSYNC-1:0] sync_ff;

    // two flops per pin; only the second stage is read
    genvar g;
    generate
        for (g = 0; g < NSYNC; g = g + 1) begin : pin_sync
            always @(posedge clock) begin
                if (rst) begin
                    meta_ff[g] <= 1'b0;
                    sync_ff[g] <= 1'b0;
                end else begin
                    meta_ff[g] <= pins_raw[g];
                    sync_ff[g] <= meta_ff[g];
                end
            end
        end
    endgenerate

    reg  tck_prev_ff;
    wire tck_rise = sync_ff[SI_TCK] && !tck_prev_ff;
    wire tck_fall = !sync_ff[SI_TCK] && tck_prev_ff;

    // mode decode
    wire mode_ok = (sync_ff[SI_MODE1:SI_MODE0] == 2'b00);
    wire scan_en = mode_ok && sync_ff[SI_PGOOD];
    wire fitted  = !sync_ff[SI_FIT];

    // software registers
    reg [3:0] ctrl_ff;
    reg [7:0] rx_data_ff;
    reg [3:0] irq_stat_ff;
    reg [3:0] irq_mask_ff;
    reg       scan_en_prev_ff;
    reg       mode_ok_prev_ff;

    wire status_val = ctrl_ff[`TIM_CTRL_STATUS];
    wire srom_run   = ctrl_ff[`TIM_CTRL_SROM_RUN];
    wire term_mode  = ctrl_ff[`TIM_CTRL_TERM];
    wire tx_bit     = ctrl_ff[`TIM_CTRL_TX];

    // serial rom clocking and receive
    reg [3:0] div_ff;
    reg [2:0] bit_cnt_ff;
    reg [7:0] rx_sh_ff;
    reg       rx_byte_ff;
    wire srom_active = mode_ok && fitted && srom_run && !term_mode;
    wire div_done    = (div_ff == `TIM_SROM_HALF - 4'h1);

    // tap and watchdog
    wire [4:0] ir_val;
    wire       tap_tdo;
    wire       tap_tdo_oe;
    wire       pulse;
    wire       timeout_fired;

    tap_core u_tap (
        .clock          (clock),
        .rst            (rst),
        .enable         (scan_en),
        .tck_rise       (tck_rise),
        .tck_fall       (tck_fall),
        .tms            (sync_ff[SI_TMS]),
        .tdi            (sync_ff[SI_TDI]),
        .trst_n         (sync_ff[SI_TRST]),
        .bsr_tdo        (bsr_tdo_in),
        .tdo_ff         (tap_tdo),
        .tdo_oe_ff      (tap_tdo_oe),
        .highz_ff       (chip_tristate),
        .extest_ff      (bsr_drive_pins),
        .bsr_capture_ff (bsr_capture),
        .bsr_shift_ff   (bsr_shift),
        .bsr_update_ff  (bsr_update),
        .ir_out         (ir_val)
    );

    timeout_pulse #(
        .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
    ) u_watchdog (
        .clock    (clock),
        .rst      (rst),
        .retire   (retire),
        .sys_tick (sys_tick),
        .pulse_ff (pulse),
        .fired_ff (timeout_fired)
    );

    assign tdo_out = tap_tdo;
    assign tdo_oe  = tap_tdo_oe;

    always @(posedge clock) begin
        if (rst)
            tck_prev_ff <= 1'b0;
        else
            tck_prev_ff <= sync_ff[SI_TCK];
    end

    // control register writes
    always @(posedge clock) begin
        if (rst)
            ctrl_ff <= `TIM_CTRL_RESET;
        else if (reg_wr && reg_addr == `TIM_REG_CTRL)
            ctrl_ff <= reg_wdata[3:0];
    end

    always @(posedge clock) begin
        if (rst)
            irq_mask_ff <= 4'h0;
        else if (reg_wr && reg_addr == `TIM_REG_IRQ_MASK)
            irq_mask_ff <= reg_wdata[3:0];
    end

    // serial rom clock divider and byte assembly
    always @(posedge clock) begin
        if (rst) begin
            div_ff           <= 4'h0;
            bit_cnt_ff       <= 3'h0;
            rx_sh_ff         <= 8'h0;
            rx_data_ff       <= 8'h0;
            rx_byte_ff       <= 1'b0;
            serial_clk_tx_ff <= 1'b0;
            srom_enable_n_ff <= 1'b1;
        end else begin
            rx_byte_ff       <= 1'b0;
            srom_enable_n_ff <= !srom_active;
            if (!mode_ok) begin
                // factory modes redefine the pins; keep them quiet
                div_ff           <= 4'h0;
                bit_cnt_ff       <= 3'h0;
                serial_clk_tx_ff <= 1'b0;
            end else if (term_mode) begin
                div_ff           <= 4'h0;
                bit_cnt_ff       <= 3'h0;
                serial_clk_tx_ff <= tx_bit;
            end else if (srom_active) begin
                div_ff <= div_done ? 4'h0 : div_ff + 4'h1;
                if (div_done) begin
                    serial_clk_tx_ff <= !serial_clk_tx_ff;
                    // data sampled as the rom clock rises
                    if (!serial_clk_tx_ff) begin
                        rx_sh_ff   <= {rx_sh_ff[6:0], sync_ff[SI_RX]};
                        bit_cnt_ff <= bit_cnt_ff + 3'h1;
                        if (bit_cnt_ff == 3'h7) begin
                            rx_data_ff <= {rx_sh_ff[6:0], sync_ff[SI_RX]};
                            rx_byte_ff <= 1'b1;
                        end
                    end
                end
            end else begin
                div_ff           <= 4'h0;
                bit_cnt_ff       <= 3'h0;
                serial_clk_tx_ff <= 1'b0;
            end
        end
    end

    // sticky events; a set in the clearing cycle wins
    wire [3:0] events;
    assign events[`TIM_EV_TIMEOUT]  = timeout_fired;
    assign events[`TIM_EV_RX_BYTE]  = rx_byte_ff;
    assign events[`TIM_EV_MODE_BAD] = mode_ok_prev_ff && !mode_ok;
    assign events[`TIM_EV_SCAN_CHG] = scan_en_prev_ff != scan_en;

    wire [3:0] w1c = (reg_wr && reg_addr == `TIM_REG_IRQ_STAT) ?
                     reg_wdata[3:0] : 4'h0;
    wire [3:0] nxt_irq_stat = (irq_stat_ff & ~w1c) | events;

    always @(posedge clock) begin
        if (rst) begin
            irq_stat_ff     <= 4'h0;
            irq_ff          <= 1'b0;
            mode_ok_prev_ff <= 1'b1;
            scan_en_prev_ff <= 1'b0;
        end else begin
            irq_stat_ff     <= nxt_irq_stat;
            irq_ff          <= |(nxt_irq_stat & irq_mask_ff);
            mode_ok_prev_ff <= mode_ok;
            scan_en_prev_ff <= scan_en;
        end
    end

    // status pin: written value or timeout pulse
    always @(posedge clock) begin
        if (rst)
            test_status_ff <= 1'b0;
        else
            test_status_ff <= status_val | pulse;
    end

    // read port, data one cycle after the strobe
    reg [7:0] rd_mux;
    always @* begin
        rd_mux = 8'h0;
        case (reg_addr)
            `TIM_REG_CTRL:     rd_mux = {4'h0, ctrl_ff};
            `TIM_REG_STATE: begin
                rd_mux[`TIM_ST_MODE_OK] = mode_ok;
                rd_mux[`TIM_ST_SCAN_EN] = scan_en;
                rd_mux[`TIM_ST_FITTED]  = fitted;
                rd_mux[`TIM_ST_RX]      = sync_ff[SI_RX];
                rd_mux[`TIM_ST_PULSE]   = pulse;
            end
            `TIM_REG_RXDATA:   rd_mux = rx_data_ff;
            `TIM_REG_IRQ_STAT: rd_mux = {4'h0, irq_stat_ff};
            `TIM_REG_IRQ_MASK: rd_mux = {4'h0, irq_mask_ff};
            `TIM_REG_IR:       rd_mux = {3'h0, ir_val};
            default:           rd_mux = 8'h0;
        endcase
    end

    always @(posedge clock) begin
        if (rst)
            reg_rdata_ff <= 8'h0;
        else if (reg_rd)
            reg_rdata_ff <= rd_mux;
        else
            reg_rdata_ff <= 8'h0;
    end
endmodule // test_interface_mode_select
`default_nettype wire

// ### logic/timeout_pulse.v
/*
 * Retire watchdog and status pulse: fires when no instruction retires for
 * the timeout count, then shapes a pulse of the pulse count aligned to
 * system clock ticks. Assumes retire and sys_tick are same-domain pulses.
 */
`timescale 1ns/10ps
`default_nettype none
`include "test_if_map.vh"
module timeout_pulse #(
    parameter [31:0] TIMEOUT_CYCLES = `TIM_TIMEOUT_CYCLES
) (
    // clock and reset
    input  wire clock,
    input  wire rst,
    // core events
    input  wire retire,
    input  wire sys_tick,
    // results
    output reg  pulse_ff,
    output reg  fired_ff
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ARM  = 2'h1;
    localparam [1:0] ST_HIGH = 2'h2;
    localparam [1:0] ST_TAIL = 2'h3;

    reg [31:0] wait_ff;
    reg [8:0]  width_ff;
    reg [1:0]  state_ff;
    wire       expire = !retire && (wait_ff == TIMEOUT_CYCLES - 32'h1);

    always @(posedge clock) begin
        if (rst) begin
            wait_ff  <= 32'h0;
            width_ff <= 9'h0;
            state_ff <= ST_IDLE;
            pulse_ff <= 1'b0;
            fired_ff <= 1'b0;
        end else begin
            fired_ff <= expire;
            if (retire || expire)
                wait_ff <= 32'h0;
            else
                wait_ff <= wait_ff + 32'h1;
            case (state_ff)
                ST_IDLE: if (expire) state_ff <= ST_ARM;
                ST_ARM: if (sys_tick) begin
                    // edges land on system clock ticks
                    state_ff <= ST_HIGH;
                    pulse_ff <= 1'b1;
                    width_ff <= 9'h1;
                end
                ST_HIGH: begin
                    width_ff <= width_ff + 9'h1;
                    if (width_ff == `TIM_PULSE_CYCLES - 9'h1)
                        state_ff <= ST_TAIL;
                end
                ST_TAIL: if (sys_tick) begin
                    state_ff <= ST_IDLE;
                    pulse_ff <= 1'b0;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule // timeout_pulse
`default_nettype wire

// ### tb/scan_partner.sv
/*
 * Far side: boundary-scan tester and serial boot rom.
 * Assumes run and load are called from one process at a time.
 */
`timescale 1ns/10ps
`default_nettype none
module scan_partner (
    // scan access pins
    output var logic  tck_in,
    output var logic  tms_in,
    output var logic  tdi_in,
    output var logic  trst_n_in,
    input  wire logic tdo_out,
    // serial rom pins
    input  wire logic serial_clk_tx_ff,
    input  wire logic srom_enable_n_ff,
    output wire logic serial_rx_in,
    output wire logic srom_fitted_n_in
);
    logic [7:0] rom_byte = 8'h00;
    logic [2:0] rom_bit = 3'h0;
    assign srom_fitted_n_in = 1'b0;
    // released line shows the inverse, not a stale bit
    assign serial_rx_in = srom_enable_n_ff ? ~rom_byte[0]
                                           : rom_byte[3'h7 - rom_bit];
    // bit moves on the falling edge, away from the sampling edge
    always @(negedge serial_clk_tx_ff)
        if (!srom_enable_n_ff)
            rom_bit <= rom_bit + 3'h1;
    initial begin
        tck_in = 1'b0;
        tms_in = 1'b1;
        tdi_in = 1'b0;
        trst_n_in = 1'b0;
        #100 trst_n_in = 1'b1;
    end
    task automatic load(input logic [7:0] b);
        rom_byte = b;
        rom_bit = 3'h0;
    endtask
    // tck only runs inside a frame, 64 ns period
    task automatic run(input logic [31:0] m, input logic [31:0] d,
                       input int steps, output logic [31:0] q);
        q = 32'h0;
        for (int i = 0; i < steps; i++) begin
            tms_in = m[i];
            tdi_in = d[i];
            #32 q[i] = tdo_out;
            tck_in = 1'b1;
            #32 tck_in = 1'b0;
        end
    endtask
endmodule // scan_partner
`default_nettype wire

// ### tb/test_interface_mode_select_bench.sv
/*
 * Bench of the test interface front end: registers, rom, scan, gating
 * and timeout. Assumes scan_partner on the far side.
 */
`timescale 1ns/10ps
`default_nettype none
`include "test_if_map.vh"
module test_interface_mode_select_bench;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [1:0] port_mode_in = 2'b00;
    logic       power_good_in = 1'b1;
    logic       retire = 1'b0;
    logic       sys_tick = 1'b0;
    logic       bsr_tdo_in = 1'b0;
    logic       stop_retire = 1'b0;
    logic [4:0] tick_cnt = 5'h00;
    logic [7:0] bsr_cnt = 8'h00;
    logic [7:0] v, w;
    logic [31:0] q;
    int         n, miscompares = 0, check_count = 0;
    wire [7:0]  reg_rdata_ff;
    wire        serial_clk_tx_ff, srom_enable_n_ff, srom_fitted_n_in;
    wire        serial_rx_in, tck_in, tms_in, tdi_in, trst_n_in, tdo_out;
    wire        tdo_oe, bsr_capture, bsr_shift, bsr_update, bsr_drive_pins;
    wire        chip_tristate, test_status_ff, irq_ff;

    test_interface_mode_select #(.TIMEOUT_CYCLES(32'd100)) u_dut (.*);
    scan_partner u_far (.*);

    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        tick_cnt <= tick_cnt + 5'h01;
        sys_tick <= (tick_cnt == 5'h1f);
        // update in bit 6, capture in bit 4, shifts in the low bits
        bsr_cnt <= bsr_cnt + {1'b0, bsr_update, 1'b0, bsr_capture, 4'h0}
                   + {7'h0, bsr_shift};
        retire <= !stop_retire && ($urandom_range(1) == 1);
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_ff;
    endtask
    task automatic wait_sig(input bit on_status, input logic lvl);
        n = 0;
        while ((on_status ? test_status_ff : irq_ff) !== lvl) begin
            if (++n > 2000) begin
                miscompares++;
                print_verdict();
            end
            @(posedge clock);
            #1;
        end
    endtask
    task automatic scan_ir(input logic [4:0] code);
        u_far.run(32'h606, {22'h0, code, 5'h00}, 12, q);
        repeat (4) @(posedge clock);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        v = 8'($urandom(3947));
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        wr(`TIM_REG_STATE, 8'hff);
        rd(`TIM_REG_STATE, v);
        chk(v, 8'h0f);
        chk({7'h0, test_status_ff}, 8'h00);
        rd(`TIM_REG_CTRL, v);
        chk(v, 8'h00);
        rd(`TIM_REG_IR, v);
        chk(v, 8'h1f);
        rd(4'hf, v);
        chk(v, 8'h00);
        for (int i = 0; i < 6; i++) begin
            w = (i == 0) ? 8'hff : 8'($urandom) & 8'h0d;
            wr(`TIM_REG_CTRL, w);
            rd(`TIM_REG_CTRL, v);
            chk(v, w & 8'h0f);
            chk({7'h0, test_status_ff}, {7'h0, w[0]});
            if (w[2])
                chk({7'h0, serial_clk_tx_ff}, {7'h0, w[3]});
        end
        // rom byte with the receive event unmasked
        v = 8'($urandom);
        u_far.load(v);
        wr(`TIM_REG_CTRL, 8'h00);
        wr(`TIM_REG_IRQ_STAT, 8'h0f);
        wr(`TIM_REG_IRQ_MASK, 8'h02);
        wr(`TIM_REG_CTRL, 8'h02);
        wait_sig(1'b0, 1'b1);
        // stop only in the low phase, a cut high phase is no rom clock
        for (n = 0; n < 20 && serial_clk_tx_ff === 1'b1; n++)
            @(negedge clock);
        chk({7'h0, serial_clk_tx_ff}, 8'h00);
        wr(`TIM_REG_CTRL, 8'h00);
        rd(`TIM_REG_RXDATA, w);
        chk(w, v);
        wr(`TIM_REG_IRQ_STAT, 8'h02);
        rd(`TIM_REG_IRQ_STAT, w);
        chk(w & 8'h02, 8'h00);
        chk({7'h0, irq_ff}, 8'h00);
        scan_ir(`TIM_IR_HIGHZ);
        chk({3'h0, q[9:5]}, 8'h01);
        chk({7'h0, chip_tristate}, 8'h01);
        rd(`TIM_REG_IR, v);
        chk(v, 8'h05);
        scan_ir(`TIM_IR_EXTEST);
        chk({7'h0, bsr_drive_pins}, 8'h01);
        u_far.run(32'h61, 32'h5, 8, q);
        chk(bsr_cnt, 8'h53);
        wr(`TIM_REG_IRQ_MASK, 8'h04);
        @(posedge clock);
        port_mode_in <= 2'($urandom_range(3, 1));
        wait_sig(1'b0, 1'b1);
        repeat (8) @(posedge clock);
        #1 chk({6'h0, bsr_drive_pins, serial_clk_tx_ff}, 8'h00);
        rd(`TIM_REG_IR, v);
        chk(v, 8'h1f);
        wr(`TIM_REG_IRQ_MASK, 8'h00);
        wr(`TIM_REG_IRQ_STAT, 8'h0f);
        scan_ir(`TIM_IR_HIGHZ);
        chk({6'h0, chip_tristate, irq_ff}, 8'h00);
        @(posedge clock);
        port_mode_in <= 2'b00;
        power_good_in <= 1'b0;
        scan_ir(`TIM_IR_HIGHZ);
        chk({7'h0, chip_tristate}, 8'h00);
        @(posedge clock);
        power_good_in <= 1'b1;
        scan_ir(`TIM_IR_HIGHZ);
        chk({7'h0, chip_tristate}, 8'h01);
        // retire stops: watchdog pulse on the status pin
        wr(`TIM_REG_IRQ_STAT, 8'h0f);
        wr(`TIM_REG_IRQ_MASK, 8'h01);
        @(posedge clock);
        stop_retire <= 1'b1;
        wait_sig(1'b1, 1'b1);
        for (n = 0; n < 400 && test_status_ff === 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        chk({7'h0, (n >= 256 && n <= 288)}, 8'h01);
        chk({7'h0, irq_ff}, 8'h01);
        wait_sig(1'b1, 1'b1);
        repeat (20) @(posedge clock);
        rst <= 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        stop_retire <= 1'b0;
        @(posedge clock);
        #1 chk({6'h0, test_status_ff, irq_ff}, 8'h00);
        print_verdict();
    end
endmodule // test_interface_mode_select_bench

bind test_interface_mode_select test_interface_mode_select_properties
    u_props (.*);
`default_nettype wire

// ### tb/test_interface_mode_select_properties.sv
/*
 * Checker of the test interface front end, seeing only top ports.
 * Assumes it is bound onto the top module by name.
 */
`timescale 1ns/10ps
`default_nettype none
module test_interface_mode_select_properties (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata_ff,
    // pins
    input wire logic [1:0] port_mode_in,
    input wire logic       power_good_in,
    input wire logic       serial_clk_tx_ff,
    input wire logic       srom_enable_n_ff,
    input wire logic       tdo_oe,
    input wire logic       bsr_capture,
    input wire logic       bsr_shift,
    input wire logic       bsr_update,
    input wire logic       bsr_drive_pins,
    input wire logic       chip_tristate,
    input wire logic       test_status_ff
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire bsr_op = bsr_capture | bsr_shift | bsr_update;
    wire scan_busy = tdo_oe | bsr_op | bsr_drive_pins | chip_tristate;
    wire mode_bad = port_mode_in != 2'b00;
    wire rom_on = serial_clk_tx_ff & ~srom_enable_n_ff;
    property p_rd_idle; !reg_rd |=> reg_rdata_ff == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata");
    property p_set; reg_wr && reg_addr == 4'h0 && reg_wdata[0]
        |=> ##1 test_status_ff; endproperty
    a_set: assert property (p_set) else $error("status set");
    property p_rst_low; $fell(rst) |-> !test_status_ff; endproperty
    a_rst_low: assert property (p_rst_low) else $error("reset");
    // six cycles cover the pin sync and the tap reset
    property p_gate; (mode_bad || !power_good_in)[*6] |-> !scan_busy;
    endproperty
    a_gate: assert property (p_gate) else $error("scan gate");
    property p_factory; mode_bad[*6] |-> !serial_clk_tx_ff; endproperty
    a_factory: assert property (p_factory) else $error("factory");
    property p_rom; $rose(rom_on) |-> rom_on[*8] ##1 !rom_on; endproperty
    a_rom: assert property (p_rom) else $error("rom clock");
    property p_excl; !(chip_tristate && bsr_drive_pins); endproperty
    a_excl: assert property (p_excl) else $error("tristate");
    property p_bsr; bsr_op |=> !bsr_op; endproperty
    a_bsr: assert property (p_bsr) else $error("bsr pulse");
    c_rom: cover property ($rose(rom_on));
    c_tri: cover property ($rose(chip_tristate));
    c_pulse: cover property (test_status_ff [*8]);
endmodule // test_interface_mode_select_properties
`default_nettype wire
